/* rtl/lmcs_pkg.sv */
/*
  Package for the loop mode and calibrate/sync control block.
  Assumes a plain register port with 12-bit byte addresses and 8-bit data.
*/
package lmcs_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam logic [11:0] LOOP_MODE_OFFS = 12'hA01;
  localparam logic [11:0] CAL_SYNC_OFFS = 12'hA02;
  localparam logic [11:0] UPDATE_OFFS = 12'hA10;
  localparam logic [11:0] STATUS_OFFS = 12'hA11;
  localparam int HOLD_BIT = 6;
  localparam int FREE_BIT = 5;
  localparam int MODE_LSB = 3;
  localparam int SYNC_BIT = 1;
  localparam int CAL_BIT = 0;
  localparam logic [7:0] LOOP_MODE_RST = 8'h00;
  localparam logic [7:0] CAL_SYNC_RST = 8'h00;
  localparam logic [7:0] LOOP_MODE_MASK = 8'h7F;
  localparam logic [7:0] CAL_SYNC_MASK = 8'h03;
  localparam logic [7:0] UPDATE_VAL = 8'h01;
  localparam logic [1:0] SEL_AUTO = 2'h0;
  localparam logic [1:0] SEL_FALLBACK = 2'h1;
  localparam logic [1:0] SEL_HOLDOVER = 2'h2;
  localparam logic [1:0] SEL_MANUAL = 2'h3;
  localparam int CLK_HZ = 20000000;
  localparam int CAL_TIME_US = 2000;
  localparam int CAL_CYCLES = CAL_TIME_US * (CLK_HZ / 1000000);

  typedef enum logic [1:0] {
    LMCS_LOOP_NORMAL,
    LMCS_LOOP_HOLDOVER,
    LMCS_LOOP_FREERUN
  } lmcs_loop_t;

  typedef enum {
    LMCS_CAL_IDLE,
    LMCS_CAL_ARMED,
    LMCS_CAL_RUN
  } lmcs_cal_state_t;

  typedef struct packed {
    logic [2:0] ref_sel;
    logic ref_active;
    logic [1:0] loop_state;
    logic use_freerun_word;
  } lmcs_ref_t;
endpackage : lmcs_pkg

/* rtl/lmcs_sync3.sv */
/*
  Three-flop input conditioner for the reference validity pins.
  Assumes asynchronous inputs; output changes once stages two and three agree.
*/
`timescale 1ns/1ps
`default_nettype none
module lmcs_sync3 #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [WIDTH-1:0] async_i,
  output var logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] out_next;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_comb begin
        out_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : sync_o[g];
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      sync_o <= '0;
    end else begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      sync_o <= out_next;
    end
  end
endmodule : lmcs_sync3
`default_nettype wire

/* rtl/lmcs_top.sv */
/*
  Loop mode control and calibrate/sync control for a clock synchronizer.
  Assumes a single-cycle register port, an automatic reference chooser outside
  that presents its pick, and reference validity pins from another domain.
*/
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module lmcs_top
  import lmcs_pkg::*;
#(
  parameter int CAL_CYCLES_P = CAL_CYCLES
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [11:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output var logic [7:0] rdata_o,
  input wire logic [7:0] ref_valid_i,
  input wire logic [2:0] auto_ref_i,
  input wire logic auto_ref_ok_i,
  input wire logic pll_enable_i,
  output var logic [2:0] active_ref_o,
  output var logic ref_active_o,
  output var logic [1:0] loop_state_o,
  output var logic use_freerun_word_o,
  output var logic dist_stall_o,
  output var logic dist_sync_o,
  output var logic cal_busy_o,
  output var logic base_clk_stop_o,
  output var logic cal_band_sel_o,
  output var logic cal_amp_sel_o
);
  logic [7:0] ref_valid_s;
  logic [7:0] loop_reg;
  logic [7:0] loop_next;
  logic [7:0] cs_reg;
  logic [7:0] cs_next;
  logic [7:0] rdata_next;
  logic cal_prev_reg;
  logic cal_prev_next;
  logic sync_prev_reg;
  logic sync_prev_next;
  logic update;
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  lmcs_cal_state_t cal_reg;
  lmcs_cal_state_t cal_next;
  lmcs_ref_t ref_reg;
  lmcs_ref_t ref_next;
  logic stall_next;
  logic syncp_next;
  logic [1:0] mode;
  logic [2:0] user_ref;
  logic user_ok;

  lmcs_sync3 #(.WIDTH(8)) u_valid_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .async_i(ref_valid_i),
    .sync_o(ref_valid_s)
  );

  // Update strobe is any write to the update register with bit 0 set
  assign update = wr_i && (addr_i == UPDATE_OFFS) && wdata_i[0];

  always_comb begin
    loop_next = loop_reg;
    cs_next = cs_reg;
    rdata_next = 8'h00;
    if (wr_i && addr_i == LOOP_MODE_OFFS) begin
      loop_next = wdata_i & LOOP_MODE_MASK;
    end else if (wr_i && addr_i == CAL_SYNC_OFFS) begin
      cs_next = wdata_i & CAL_SYNC_MASK;
    end
    if (rd_i) begin
      if (addr_i == LOOP_MODE_OFFS) begin
        rdata_next = loop_reg;
      end else if (addr_i == CAL_SYNC_OFFS) begin
        rdata_next = cs_reg;
      end else if (addr_i == STATUS_OFFS) begin
        rdata_next = {ref_reg.ref_active, ref_reg.ref_sel, ref_reg.loop_state,
                      dist_stall_o, cal_busy_o};
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  // Reference selection logic; its outputs are registered below
  assign mode = loop_reg[MODE_LSB+1:MODE_LSB];
  assign user_ref = loop_reg[2:0]; // Code order is A, AA, B, BB, ...
  assign user_ok = ref_valid_s[user_ref];

  always_comb begin
    ref_next.use_freerun_word = 1'b0;
    ref_next.ref_sel = auto_ref_i;
    ref_next.ref_active = auto_ref_ok_i;
    ref_next.loop_state = LMCS_LOOP_NORMAL;
    case (mode)
      SEL_AUTO: begin
        ref_next.ref_sel = auto_ref_i;
        ref_next.ref_active = auto_ref_ok_i;
        ref_next.loop_state = auto_ref_ok_i ? LMCS_LOOP_NORMAL : LMCS_LOOP_HOLDOVER;
      end
      SEL_FALLBACK: begin
        ref_next.ref_sel = user_ok ? user_ref : auto_ref_i;
        ref_next.ref_active = user_ok || auto_ref_ok_i;
        ref_next.loop_state = ref_next.ref_active ? LMCS_LOOP_NORMAL : LMCS_LOOP_HOLDOVER;
      end
      SEL_HOLDOVER: begin
        ref_next.ref_sel = user_ref;
        ref_next.ref_active = user_ok;
        ref_next.loop_state = user_ok ? LMCS_LOOP_NORMAL : LMCS_LOOP_HOLDOVER;
      end
      default: begin
        ref_next.ref_sel = user_ref;
        ref_next.ref_active = 1'b1;
        ref_next.loop_state = LMCS_LOOP_NORMAL;
      end
    endcase
    if (loop_reg[HOLD_BIT]) begin
      ref_next.ref_active = 1'b0;
      ref_next.loop_state = LMCS_LOOP_HOLDOVER;
    end
    // Checked last so free-run overrides a forced holdover
    if (loop_reg[FREE_BIT]) begin
      ref_next.ref_active = 1'b0;
      ref_next.loop_state = LMCS_LOOP_FREERUN;
      ref_next.use_freerun_word = 1'b1;
    end
  end

  // Distribution stall and sync
  always_comb begin
    sync_prev_next = cs_reg[SYNC_BIT];
    stall_next = cs_reg[SYNC_BIT];
    syncp_next = sync_prev_reg && !cs_reg[SYNC_BIT];
  end

  // Calibration: the rise is latched, then consumed by the next update made while pll_enable_i is high.
  // Software must clear and re-set the bit to rearm
  always_comb begin
    cal_prev_next = cs_reg[CAL_BIT];
    cal_next = cal_reg;
    cnt_next = cnt_reg;
    case (cal_reg)
      LMCS_CAL_IDLE: begin
        if (cs_reg[CAL_BIT] && !cal_prev_reg) begin
          cal_next = LMCS_CAL_ARMED;
        end
      end
      LMCS_CAL_ARMED: begin
        if (!cs_reg[CAL_BIT]) begin
          cal_next = LMCS_CAL_IDLE;
        end else if (update && pll_enable_i) begin
          cal_next = LMCS_CAL_RUN;
          cnt_next = 32'(CAL_CYCLES_P - 1);
        end
      end
      default: begin
        if (cnt_reg == 32'h00000000) begin
          cal_next = LMCS_CAL_IDLE;
        end else begin
          cnt_next = cnt_reg - 32'h00000001;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      loop_reg <= LOOP_MODE_RST;
      cs_reg <= CAL_SYNC_RST;
      rdata_o <= 8'h00;
      cal_prev_reg <= 1'b0;
      sync_prev_reg <= 1'b0;
      cal_reg <= LMCS_CAL_IDLE;
      cnt_reg <= 32'h00000000;
      ref_reg <= '0;
      dist_stall_o <= 1'b0;
      dist_sync_o <= 1'b0;
      cal_busy_o <= 1'b0;
      base_clk_stop_o <= 1'b0;
      cal_band_sel_o <= 1'b0;
      cal_amp_sel_o <= 1'b0;
      active_ref_o <= 3'h0;
      ref_active_o <= 1'b0;
      loop_state_o <= 2'h0;
      use_freerun_word_o <= 1'b0;
    end else begin
      loop_reg <= loop_next;
      cs_reg <= cs_next;
      rdata_o <= rdata_next;
      cal_prev_reg <= cal_prev_next;
      sync_prev_reg <= sync_prev_next;
      cal_reg <= cal_next;
      cnt_reg <= cnt_next;
      ref_reg <= ref_next;
      dist_stall_o <= stall_next;
      dist_sync_o <= syncp_next;
      cal_busy_o <= (cal_next == LMCS_CAL_RUN);
      base_clk_stop_o <= (cal_next == LMCS_CAL_RUN);
      cal_band_sel_o <= (cal_next == LMCS_CAL_RUN);
      cal_amp_sel_o <= (cal_next == LMCS_CAL_RUN);
      active_ref_o <= ref_next.ref_sel;
      ref_active_o <= ref_next.ref_active;
      loop_state_o <= ref_next.loop_state;
      use_freerun_word_o <= ref_next.use_freerun_word;
    end
  end

  sequence s_cal_arm;
    cal_reg == LMCS_CAL_ARMED && update && pll_enable_i && cs_reg[CAL_BIT];
  endsequence

  property p_cal_start;
    @(posedge clk_i) disable iff (srst_i) s_cal_arm |=> cal_busy_o && base_clk_stop_o;
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("Calibration did not start");

  property p_cal_needs_update;
    @(posedge clk_i) disable iff (srst_i) $rose(cal_busy_o) |-> $past(update);
  endproperty
  a_cal_needs_update: assert property (p_cal_needs_update) else $error("No update");

  property p_clk_stop;
    @(posedge clk_i) disable iff (srst_i) cal_busy_o == base_clk_stop_o;
  endproperty
  a_clk_stop: assert property (p_clk_stop) else $error("Clock stop mismatch");

  property p_freerun;
    @(posedge clk_i) disable iff (srst_i)
      loop_reg[FREE_BIT] |=> loop_state_o == LMCS_LOOP_FREERUN && use_freerun_word_o;
  endproperty
  a_freerun: assert property (p_freerun) else $error("Free-run not entered");

  property p_free_over_hold;
    @(posedge clk_i) disable iff (srst_i)
      loop_reg[FREE_BIT] && loop_reg[HOLD_BIT] |=> loop_state_o != LMCS_LOOP_HOLDOVER;
  endproperty
  a_free_over_hold: assert property (p_free_over_hold) else $error("Holdover won");

  property p_manual;
    @(posedge clk_i) disable iff (srst_i)
      mode == SEL_MANUAL && !loop_reg[FREE_BIT] && !loop_reg[HOLD_BIT] |=>
        active_ref_o == $past(user_ref) && ref_active_o;
  endproperty
  a_manual: assert property (p_manual) else $error("Manual mode ref wrong");

  property p_auto;
    @(posedge clk_i) disable iff (srst_i) mode == SEL_AUTO |=> active_ref_o == $past(auto_ref_i);
  endproperty
  a_auto: assert property (p_auto) else $error("Auto mode ref wrong");

  property p_holdmode;
    @(posedge clk_i) disable iff (srst_i)
      mode == SEL_HOLDOVER && !user_ok && !loop_reg[FREE_BIT] |=>
        loop_state_o == LMCS_LOOP_HOLDOVER;
  endproperty
  a_holdmode: assert property (p_holdmode) else $error("Holdover not entered");

  property p_fallback;
    @(posedge clk_i) disable iff (srst_i)
      mode == SEL_FALLBACK && !user_ok |=> active_ref_o == $past(auto_ref_i);
  endproperty
  a_fallback: assert property (p_fallback) else $error("Fallback ref wrong");

  property p_stall;
    @(posedge clk_i) disable iff (srst_i) cs_reg[SYNC_BIT] |=> dist_stall_o;
  endproperty
  a_stall: assert property (p_stall) else $error("Distribution not stalled");

  property p_sync;
    @(posedge clk_i) disable iff (srst_i) $fell(cs_reg[SYNC_BIT]) |=> dist_sync_o ##1 !dist_sync_o;
  endproperty
  a_sync: assert property (p_sync) else $error("Sync pulse wrong");

  sequence s_cal_begin;
    $rose(cal_busy_o);
  endsequence

  property p_cal_pll;
    @(posedge clk_i) disable iff (srst_i)
      s_cal_begin |-> $past(pll_enable_i) && $past(cs_reg[CAL_BIT]);
  endproperty
  a_cal_pll: assert property (p_cal_pll) else $error("Calibration without PLL");

  property p_cal_hold;
    @(posedge clk_i) disable iff (srst_i)
      cal_reg == LMCS_CAL_RUN && cnt_reg != 32'h00000000 |=> cal_busy_o && base_clk_stop_o;
  endproperty
  a_cal_hold: assert property (p_cal_hold) else $error("Calibration ended early");

  property p_cal_end;
    @(posedge clk_i) disable iff (srst_i)
      cal_reg == LMCS_CAL_RUN && cnt_reg == 32'h00000000 |=> !cal_busy_o && !base_clk_stop_o;
  endproperty
  a_cal_end: assert property (p_cal_end) else $error("Calibration did not end");

  property p_cal_select;
    @(posedge clk_i) disable iff (srst_i)
      cal_band_sel_o == cal_busy_o && cal_amp_sel_o == cal_busy_o;
  endproperty
  a_cal_select: assert property (p_cal_select) else $error("Select mismatch");

  property p_no_rearm;
    @(posedge clk_i) disable iff (srst_i)
      cal_reg == LMCS_CAL_IDLE && !(cs_reg[CAL_BIT] && !cal_prev_reg) |=> !cal_busy_o;
  endproperty
  a_no_rearm: assert property (p_no_rearm) else $error("Calibration without a rise");

  property p_stall_off;
    @(posedge clk_i) disable iff (srst_i) !cs_reg[SYNC_BIT] |=> !dist_stall_o;
  endproperty
  a_stall_off: assert property (p_stall_off) else $error("Stall held too long");

  property p_sync_src;
    @(posedge clk_i) disable iff (srst_i)
      dist_sync_o |-> $past(cs_reg[SYNC_BIT], 2) && !$past(cs_reg[SYNC_BIT]);
  endproperty
  a_sync_src: assert property (p_sync_src) else $error("Stray sync pulse");

  property p_user_ref;
    @(posedge clk_i) disable iff (srst_i)
      mode != SEL_AUTO && user_ok && !loop_reg[FREE_BIT] && !loop_reg[HOLD_BIT] |=>
        active_ref_o == $past(user_ref) && ref_active_o && loop_state_o == LMCS_LOOP_NORMAL;
  endproperty
  a_user_ref: assert property (p_user_ref) else $error("User reference not used");

  property p_hold_forced;
    @(posedge clk_i) disable iff (srst_i)
      loop_reg[HOLD_BIT] && !loop_reg[FREE_BIT] |=>
        loop_state_o == LMCS_LOOP_HOLDOVER && !ref_active_o;
  endproperty
  a_hold_forced: assert property (p_hold_forced) else $error("Holdover not forced");

  property p_word_off;
    @(posedge clk_i) disable iff (srst_i) !loop_reg[FREE_BIT] |=> !use_freerun_word_o;
  endproperty
  a_word_off: assert property (p_word_off) else $error("Free-run word left on");
endmodule : lmcs_top
`default_nettype wire

/* verification/lmcs_top_bench.sv */
/*
  Self-checking bench for lmcs_top: register access, reference choice, sync, calibration.
  Assumes the single-cycle register port and a shortened calibration count.
*/
`timescale 1ns/1ps
`default_nettype none
module lmcs_top_bench;
  import lmcs_pkg::*;
  localparam int CAL_P = 8;
  logic clk_i, srst_i, wr_i, rd_i, auto_ref_ok_i, pll_enable_i;
  logic [11:0] addr_i;
  logic [7:0] wdata_i, rdata_o, ref_valid_i, d;
  logic [2:0] auto_ref_i, active_ref_o;
  logic ref_active_o, use_freerun_word_o, dist_stall_o, dist_sync_o;
  logic cal_busy_o, base_clk_stop_o, cal_band_sel_o, cal_amp_sel_o;
  logic [1:0] loop_state_o;
  logic ua, au;
  int bad_count, tests_run, cyc, sync_cnt, busy_cnt, all_cnt;

  lmcs_top #(.CAL_CYCLES_P(CAL_P)) dut (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ref_valid_i(ref_valid_i),
    .auto_ref_i(auto_ref_i), .auto_ref_ok_i(auto_ref_ok_i), .pll_enable_i(pll_enable_i),
    .active_ref_o(active_ref_o), .ref_active_o(ref_active_o), .loop_state_o(loop_state_o),
    .use_freerun_word_o(use_freerun_word_o), .dist_stall_o(dist_stall_o),
    .dist_sync_o(dist_sync_o), .cal_busy_o(cal_busy_o), .base_clk_stop_o(base_clk_stop_o),
    .cal_band_sel_o(cal_band_sel_o), .cal_amp_sel_o(cal_amp_sel_o));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Pulses and busy cycles are counted here so a stretched or missing one shows
  always @(posedge clk_i) begin
    cyc++;
    if (dist_sync_o === 1'b1) sync_cnt++;
    if (cal_busy_o === 1'b1) busy_cnt++;
    if ({cal_busy_o, base_clk_stop_o, cal_band_sel_o, cal_amp_sel_o} === 4'hF) all_cnt++;
    if (cyc == 5000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_cnt(input int exp, input int got);
    tests_run++;
    if (got != exp) begin
      bad_count++;
      $display("unexpected at %0t: count %h expected %h", $time, got, exp);
    end
  endtask : chk_cnt

  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [7:0] v);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask : rd

  // Covers the 2-cycle output path plus the three-flop validity conditioner
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : settle

  task automatic set_in(input logic [7:0] v, input logic [2:0] a, input logic ok);
    @(posedge clk_i);
    ref_valid_i <= v;
    auto_ref_i <= a;
    auto_ref_ok_i <= ok;
  endtask : set_in

  task automatic sel_chk(input logic act, input logic [2:0] r, input logic [1:0] st);
    settle(6);
    chk(act, ref_active_o);
    chk(st, loop_state_o);
    chk(1'b0, use_freerun_word_o);
    if (act) chk(r, active_ref_o);
  endtask : sel_chk

  initial begin
    srst_i = 1'b1;
    {wr_i, rd_i, auto_ref_ok_i, pll_enable_i} = 4'h0;
    addr_i = 12'h000;
    wdata_i = 8'h00;
    ref_valid_i = 8'h00;
    auto_ref_i = 3'h0;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(LOOP_MODE_OFFS, d); chk(LOOP_MODE_RST, d);
    rd(CAL_SYNC_OFFS, d); chk(CAL_SYNC_RST, d);
    rd(12'h123, d); chk(8'h00, d);
    wr(LOOP_MODE_OFFS, 8'hFF);
    rd(LOOP_MODE_OFFS, d); chk(8'h7F, d);
    // Mode x user-valid x auto-ok; user code 5 against auto pick 2
    for (int m = 0; m < 4; m++) begin
      for (int c = 0; c < 4; c++) begin
        // Profile assignment lives outside this block, so the write must change nothing here
        if (m == 3 && c == 0) wr(12'h503, 8'h00);
        wr(LOOP_MODE_OFFS, {3'h0, m[1:0], 3'h5});
        set_in(c[0] ? 8'h20 : 8'hDF, 3'h2, c[1]);
        ua = (m != 0) && (c[0] || m == 3);
        au = !ua && c[1] && (m != 2);
        sel_chk(ua || au, ua ? 3'h5 : 3'h2, (ua || au) ? 2'h0 : 2'h1);
      end
    end
    rd(STATUS_OFFS, d); chk(8'hD0, d);
    for (int k = 0; k < 8; k++) begin
      wr(LOOP_MODE_OFFS, 8'h10 | k[7:0]);
      set_in(8'h01 << k, 3'h0, 1'b0);
      sel_chk(1'b1, k[2:0], 2'h0);
    end
    // Valid automatic pick, so the return to normal can show
    set_in(8'h80, 3'h0, 1'b1);
    wr(LOOP_MODE_OFFS, 8'h40);
    settle(3); chk(2'h1, loop_state_o); chk(1'b0, ref_active_o);
    wr(LOOP_MODE_OFFS, 8'h60);
    settle(3); chk(2'h2, loop_state_o); chk(1'b1, use_freerun_word_o);
    wr(LOOP_MODE_OFFS, 8'h20);
    settle(3); chk(2'h2, loop_state_o); chk(1'b1, use_freerun_word_o);
    wr(LOOP_MODE_OFFS, 8'h00);
    settle(3); chk(2'h0, loop_state_o); chk(1'b0, use_freerun_word_o);
    sync_cnt = 0;
    wr(CAL_SYNC_OFFS, 8'hFE);
    rd(CAL_SYNC_OFFS, d); chk(8'h02, d);
    settle(3); chk(1'b1, dist_stall_o); chk_cnt(0, sync_cnt);
    rd(STATUS_OFFS, d); chk(8'h82, d);
    wr(CAL_SYNC_OFFS, 8'h00);
    settle(4); chk(1'b0, dist_stall_o); chk_cnt(1, sync_cnt);
    busy_cnt = 0;
    all_cnt = 0;
    wr(CAL_SYNC_OFFS, 8'h01);
    wr(UPDATE_OFFS, UPDATE_VAL);
    settle(20); chk_cnt(0, busy_cnt);
    @(posedge clk_i);
    pll_enable_i <= 1'b1;
    wr(UPDATE_OFFS, UPDATE_VAL);
    settle(20); chk_cnt(CAL_P, busy_cnt); chk_cnt(CAL_P, all_cnt);
    wr(UPDATE_OFFS, UPDATE_VAL);
    settle(20); chk_cnt(CAL_P, busy_cnt);
    wr(CAL_SYNC_OFFS, 8'h00);
    wr(UPDATE_OFFS, UPDATE_VAL);
    wr(CAL_SYNC_OFFS, 8'h01);
    wr(UPDATE_OFFS, UPDATE_VAL);
    settle(20); chk_cnt(2 * CAL_P, busy_cnt);
    test_done();
  end
endmodule : lmcs_top_bench
`default_nettype wire
